// ===== rtl/ssg_cfg.svh
// address map, field positions and pin groups of the shared segment port
`ifndef SSG_CFG_SVH
`define SSG_CFG_SVH
// special-function registers
`define SSG_SFR_DATA_LOW 8'h80
`define SSG_SFR_DATA_MID 8'h90
`define SSG_SFR_DIR_MID 8'h91
`define SSG_SFR_DATA_HIGH 8'hA0
`define SSG_SFR_DIR_HIGH 8'hA1
`define SSG_SFR_DIR_LOW 8'hA2
`define SSG_SFR_DATA_TOP 8'hB0
// I/O RAM: function-select map, byte k holds segments 8k..8k+7
`define SSG_MAP_BASE 16'h2040
`define SSG_MAP_FIRST 4'h3
`define SSG_MAP_LAST 4'h8
// I/O RAM: segment control byte of segment n sits at base + n
`define SSG_SEG_BASE 16'h2100
`define SSG_SEG_FIRST 8'h18
`define SSG_SEG_LAST 8'h47
`define SSG_SEG_DIR_BIT 3
`define SSG_SEG_DATA_BIT 0
// I/O RAM: dedicated pins 56..58, one byte each
`define SSG_DED_DIR_BASE 16'h2200
`define SSG_DED_DATA_BASE 16'h2210
`define SSG_DED_DIR_BIT 7
`define SSG_DED_DATA_BIT 4
// I/O RAM: resource selectors, two per byte at [2:0] and [6:4]
`define SSG_RES_BASE 16'h2009
`define SSG_RES_BYTES 16'h0006
// pin groups
`define SSG_SEG_OFFSET 20
`define SSG_PIN_IMPL 59'h70F_BF00_6FFF_FFFF
`define SSG_PIN_DED_FIRST 56
`define SSG_PIN_PB 0
`define SSG_PIN_OPTICAL_RECEIVE 1
`define SSG_PIN_OPTICAL_TRANSMIT 2
`define SSG_RES_PINS 12
// resource selector codes
`define SSG_RES_T0 3'h2
`define SSG_RES_T1 3'h3
`define SSG_RES_HI_RISE 3'h4
`define SSG_RES_LO_RISE 3'h5
`define SSG_RES_HI_FALL 3'h6
`define SSG_RES_LO_FALL 3'h7
`endif

// ===== rtl/ssg_gpio_port.sv
// shared segment general-purpose I/O port
`timescale 1ns/1ps
`include "ssg_cfg.svh"
module ssg_gpio_port
  import ssg_pkg::*;
#(
  parameter int NPIN = 59
)(
  input wire logic clock,
  input wire logic rst,
  input wire ssg_sfr_req_t sfrReq,
  output ssg_byte_t sfrRdData,
  input wire ssg_ram_req_t ramReq,
  output ssg_byte_t ramRdData,
  input wire logic [NPIN-1:0] pinIn,
  output logic [NPIN-1:0] pinOut,
  output logic [NPIN-1:0] pinOe,
  input wire logic [NPIN-1:0] segDrive,
  input wire logic optTx,
  input wire logic optTxEnable,
  input wire logic optRxEnable,
  output logic optRx,
  output logic counter0Clock,
  output logic counter1Clock,
  output logic highPriorityInt,
  output logic lowPriorityInt
);
  if (NPIN != 59)
  begin : g_bad_npin
    $error("pin map is fixed at 59 pins");
  end

  // segment index of a shared pin into the control byte array
  function automatic logic [5:0] segIdx(input int p);
    segIdx = (p >= 4 && p <= 51) ? 6'(p - 4) : 6'h00;
  endfunction : segIdx

  localparam logic [NPIN-1:0] PIN_IMPL = NPIN'(`SSG_PIN_IMPL);

  // ==========================================================
  // configuration state
  logic [23:0] dir_q, dir_d;
  logic [30:0] data_q, data_d;
  logic [71:24] fnSel_q, fnSel_d;
  ssg_byte_t segByte_q [0:47];
  ssg_byte_t segByte_d [0:47];
  logic [2:0] dedDir_q, dedDir_d, dedData_q, dedData_d;
  logic [2:0] resSel_q [0:11];
  logic [2:0] resSel_d [0:11];
  logic [NPIN-1:0] pinIn_q;
  logic [15:0] ramOff;

  always_comb
  begin
    dir_d = dir_q;
    data_d = data_q;
    fnSel_d = fnSel_q;
    segByte_d = segByte_q;
    dedDir_d = dedDir_q;
    dedData_d = dedData_q;
    resSel_d = resSel_q;
    if (sfrReq.wr)
    begin
      // writes are kept whatever the pin mode
      if (sfrReq.addr == `SSG_SFR_DATA_LOW) data_d[7:0] = sfrReq.wrData;
      else if (sfrReq.addr == `SSG_SFR_DATA_MID) data_d[15:8] = sfrReq.wrData;
      else if (sfrReq.addr == `SSG_SFR_DATA_HIGH) data_d[23:16] = sfrReq.wrData;
      else if (sfrReq.addr == `SSG_SFR_DATA_TOP) data_d[30:24] = sfrReq.wrData[6:0];
      else if (sfrReq.addr == `SSG_SFR_DIR_LOW) dir_d[7:1] = sfrReq.wrData[7:1];
      else if (sfrReq.addr == `SSG_SFR_DIR_MID) dir_d[15:8] = sfrReq.wrData;
      else if (sfrReq.addr == `SSG_SFR_DIR_HIGH) dir_d[23:16] = sfrReq.wrData;
    end
    if (ramReq.wr)
    begin
      if (ramReq.addr >= `SSG_MAP_BASE + 16'(`SSG_MAP_FIRST)
          && ramReq.addr <= `SSG_MAP_BASE + 16'(`SSG_MAP_LAST))
        fnSel_d[int'(ramReq.addr - `SSG_MAP_BASE) * 8 +: 8] = ramReq.wrData;
      else if (ramReq.addr >= `SSG_SEG_BASE + 16'(`SSG_SEG_FIRST)
               && ramReq.addr <= `SSG_SEG_BASE + 16'(`SSG_SEG_LAST))
        segByte_d[6'(ramReq.addr - `SSG_SEG_BASE - `SSG_SEG_FIRST)] = ramReq.wrData;
      else if (ramReq.addr >= `SSG_DED_DIR_BASE && ramReq.addr < `SSG_DED_DIR_BASE + 16'h0003)
        dedDir_d[2'(ramReq.addr - `SSG_DED_DIR_BASE)] = ramReq.wrData[`SSG_DED_DIR_BIT];
      else if (ramReq.addr >= `SSG_DED_DATA_BASE && ramReq.addr < `SSG_DED_DATA_BASE + 16'h0003)
        dedData_d[2'(ramReq.addr - `SSG_DED_DATA_BASE)] = ramReq.wrData[`SSG_DED_DATA_BIT];
      else if (ramReq.addr >= `SSG_RES_BASE && ramReq.addr < `SSG_RES_BASE + `SSG_RES_BYTES)
      begin
        resSel_d[2 * int'(ramReq.addr - `SSG_RES_BASE)] = ramReq.wrData[2:0];
        resSel_d[2 * int'(ramReq.addr - `SSG_RES_BASE) + 1] = ramReq.wrData[6:4];
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dir_q <= '0;
      data_q <= '0;
      fnSel_q <= '0;
      dedDir_q <= '0;
      dedData_q <= '0;
      pinIn_q <= '0;
      for (int i = 0; i < 48; i++) segByte_q[i] <= 8'h00;
      for (int i = 0; i < 12; i++) resSel_q[i] <= 3'h0;
    end
    else
    begin
      dir_q <= dir_d;
      data_q <= data_d;
      fnSel_q <= fnSel_d;
      segByte_q <= segByte_d;
      dedDir_q <= dedDir_d;
      dedData_q <= dedData_d;
      resSel_q <= resSel_d;
      pinIn_q <= pinIn;
    end
  end

  // ==========================================================
  // pin mode, drive and read-back level
  logic [NPIN-1:0] segMode, isDio, dirEff, dataEff, ioOut, level;
  logic [NPIN-1:0] pinOut_d, pinOe_d;

  always_comb
  begin
    for (int p = 0; p < NPIN; p++)
    begin
      segMode[p] = 1'b0;
      dirEff[p] = 1'b0;
      dataEff[p] = 1'b0;
      if (p >= 4 && p <= 51) segMode[p] = fnSel_q[p + `SSG_SEG_OFFSET];
      if (p >= 1 && p < 24) dirEff[p] = dir_q[p];
      else if (p >= 24 && p <= 51) dirEff[p] = segByte_q[segIdx(p)][`SSG_SEG_DIR_BIT];
      else if (p >= `SSG_PIN_DED_FIRST) dirEff[p] = dedDir_q[p - `SSG_PIN_DED_FIRST];
      if (p <= 30) dataEff[p] = data_q[p];
      else if (p >= 40 && p <= 51) dataEff[p] = segByte_q[segIdx(p)][`SSG_SEG_DATA_BIT];
      else if (p >= `SSG_PIN_DED_FIRST) dataEff[p] = dedData_q[p - `SSG_PIN_DED_FIRST];
    end
    isDio = PIN_IMPL & ~segMode;
    isDio[`SSG_PIN_OPTICAL_TRANSMIT] = ~optTxEnable;
    isDio[`SSG_PIN_OPTICAL_RECEIVE] = ~optRxEnable;
    ioOut = isDio & dirEff;
    level = (ioOut & dataEff) | (~ioOut & pinIn_q);
    pinOe_d = (PIN_IMPL & segMode) | ioOut;
    pinOut_d = (PIN_IMPL & segMode & segDrive) | (ioOut & dataEff);
    if (optTxEnable)
    begin
      pinOe_d[`SSG_PIN_OPTICAL_TRANSMIT] = 1'b1;
      pinOut_d[`SSG_PIN_OPTICAL_TRANSMIT] = optTx;
    end
  end

  // ==========================================================
  // internal resource tracking
  logic [7:2] resLvl_d, resLvl_q;
  logic hiInt_d, loInt_d;

  always_comb
  begin
    resLvl_d = '0;
    for (int i = 0; i < `SSG_RES_PINS; i++)
      if (isDio[i] && resSel_q[i] >= `SSG_RES_T0)
        resLvl_d[resSel_q[i]] = resLvl_d[resSel_q[i]] | pinIn_q[i];
    hiInt_d = (resLvl_d[`SSG_RES_HI_RISE] & ~resLvl_q[`SSG_RES_HI_RISE])
            | (~resLvl_d[`SSG_RES_HI_FALL] & resLvl_q[`SSG_RES_HI_FALL]);
    loInt_d = (resLvl_d[`SSG_RES_LO_RISE] & ~resLvl_q[`SSG_RES_LO_RISE])
            | (~resLvl_d[`SSG_RES_LO_FALL] & resLvl_q[`SSG_RES_LO_FALL]);
  end

  // ==========================================================
  // registered outputs and read data
  ssg_byte_t sfrRd_d, ramRd_d;

  always_comb
  begin
    sfrRd_d = 8'h00;
    ramRd_d = 8'h00;
    ramOff = 16'h0000;
    if (sfrReq.addr == `SSG_SFR_DATA_LOW) sfrRd_d = level[7:0];
    else if (sfrReq.addr == `SSG_SFR_DATA_MID) sfrRd_d = level[15:8];
    else if (sfrReq.addr == `SSG_SFR_DATA_HIGH) sfrRd_d = level[23:16];
    else if (sfrReq.addr == `SSG_SFR_DATA_TOP) sfrRd_d = {1'b0, level[30:24]};
    else if (sfrReq.addr == `SSG_SFR_DIR_LOW) sfrRd_d = {dir_q[7:1], 1'b0};
    else if (sfrReq.addr == `SSG_SFR_DIR_MID) sfrRd_d = dir_q[15:8];
    else if (sfrReq.addr == `SSG_SFR_DIR_HIGH) sfrRd_d = dir_q[23:16];
    if (ramReq.addr >= `SSG_MAP_BASE + 16'(`SSG_MAP_FIRST)
        && ramReq.addr <= `SSG_MAP_BASE + 16'(`SSG_MAP_LAST))
      ramRd_d = fnSel_q[(int'(ramReq.addr - `SSG_MAP_BASE) * 8) +: 8];
    else if (ramReq.addr >= `SSG_SEG_BASE + 16'(`SSG_SEG_FIRST)
             && ramReq.addr <= `SSG_SEG_BASE + 16'(`SSG_SEG_LAST))
    begin
      ramOff = ramReq.addr - `SSG_SEG_BASE - 16'(`SSG_SEG_FIRST);
      ramRd_d = segByte_q[ramOff[5:0]];
      if (ramOff >= 16'h0024 && isDio[int'(ramOff) + 4])
        ramRd_d[`SSG_SEG_DATA_BIT] = level[int'(ramOff) + 4];
    end
    else if (ramReq.addr >= `SSG_DED_DIR_BASE && ramReq.addr < `SSG_DED_DIR_BASE + 16'h0003)
      ramRd_d[`SSG_DED_DIR_BIT] = dedDir_q[2'(ramReq.addr - `SSG_DED_DIR_BASE)];
    else if (ramReq.addr >= `SSG_DED_DATA_BASE && ramReq.addr < `SSG_DED_DATA_BASE + 16'h0003)
      ramRd_d[`SSG_DED_DATA_BIT] =
        level[`SSG_PIN_DED_FIRST + int'(ramReq.addr - `SSG_DED_DATA_BASE)];
    else if (ramReq.addr >= `SSG_RES_BASE && ramReq.addr < `SSG_RES_BASE + `SSG_RES_BYTES)
      ramRd_d = {1'b0, resSel_q[2 * int'(ramReq.addr - `SSG_RES_BASE) + 1],
                 1'b0, resSel_q[2 * int'(ramReq.addr - `SSG_RES_BASE)]};
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pinOut <= '0;
      pinOe <= '0;
      sfrRdData <= 8'h00;
      ramRdData <= 8'h00;
      optRx <= 1'b0;
      resLvl_q <= '0;
      counter0Clock <= 1'b0;
      counter1Clock <= 1'b0;
      highPriorityInt <= 1'b0;
      lowPriorityInt <= 1'b0;
    end
    else
    begin
      pinOut <= pinOut_d;
      pinOe <= pinOe_d;
      sfrRdData <= sfrRd_d;
      ramRdData <= ramRd_d;
      optRx <= optRxEnable & pinIn_q[`SSG_PIN_OPTICAL_RECEIVE];
      resLvl_q <= resLvl_d;
      counter0Clock <= resLvl_d[`SSG_RES_T0];
      counter1Clock <= resLvl_d[`SSG_RES_T1];
      highPriorityInt <= hiInt_d;
      lowPriorityInt <= loInt_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_input_default;
    $past(!fnSel_q[25] && !dir_q[5]) |-> !pinOe[5];
  endproperty
  a_input_default: assert property (p_input_default) else $error("pin 5 drives");
  property p_seg_route;
    $past(fnSel_q[25]) |-> pinOe[5] && pinOut[5] == $past(segDrive[5]);
  endproperty
  a_seg_route: assert property (p_seg_route) else $error("segment not routed");
  property p_dir_out;
    $past(!fnSel_q[25] && dir_q[5]) |-> pinOe[5] && pinOut[5] == $past(data_q[5]);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("output not driven");
  property p_sfr_write;
    sfrReq.wr && sfrReq.addr == `SSG_SFR_DATA_LOW |=> data_q[7:0] == $past(sfrReq.wrData);
  endproperty
  a_sfr_write: assert property (p_sfr_write) else $error("data write lost");
  property p_seg_dir;
    $past(!fnSel_q[44] && segByte_q[20][3]) |-> pinOe[24];
  endproperty
  a_seg_dir: assert property (p_seg_dir) else $error("segment dir ignored");
  property p_ded_pin;
    $past(dedDir_q[0]) |-> pinOe[56] && pinOut[56] == $past(dedData_q[0]);
  endproperty
  a_ded_pin: assert property (p_ded_pin) else $error("dedicated pin wrong");
  property p_optical_transmit;
    $past(optTxEnable) |-> pinOe[2] && pinOut[2] == $past(optTx);
  endproperty
  a_optical_transmit: assert property (p_optical_transmit) else $error("optical tx not on pin");
  property p_read_input;
    sfrReq.addr == `SSG_SFR_DATA_LOW && !ioOut[5] |=> sfrRdData[5] == $past(pinIn_q[5]);
  endproperty
  a_read_input: assert property (p_read_input) else $error("input read wrong");
  property p_track_or;
    isDio[5] && resSel_q[5] == `SSG_RES_T0 && pinIn_q[5] |=> counter0Clock;
  endproperty
  a_track_or: assert property (p_track_or) else $error("counter clock missed");
endmodule : ssg_gpio_port

// ===== rtl/ssg_pkg.sv
// types of the shared segment port
package ssg_pkg;
  typedef logic [7:0] ssg_byte_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    ssg_byte_t wrData;
  } ssg_sfr_req_t;
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    ssg_byte_t wrData;
  } ssg_ram_req_t;
endpackage : ssg_pkg

// ===== sim/ssg_gpio_port_tb_top.sv
// self-checking testbench of the shared segment port
`timescale 1ns/1ps
module ssg_gpio_port_tb_top
  import ssg_pkg::*;
;
  logic clock, rst, optTx, optTxEnable, optRxEnable, optRx;
  logic counter0Clock, counter1Clock, highPriorityInt, lowPriorityInt;
  ssg_sfr_req_t sfrReq;
  ssg_ram_req_t ramReq;
  ssg_byte_t sfrRdData, ramRdData, rd;
  logic [58:0] pad, pinOut, pinOe, segDrive, extLevel;
  int mismatches, totalChecks, pulses;

  // ==========================================
  // design and pads
  ssg_gpio_port ssg_gpio_port_inst (.clock(clock), .rst(rst), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .ramReq(ramReq), .ramRdData(ramRdData), .pinIn(pad),
    .pinOut(pinOut), .pinOe(pinOe), .segDrive(segDrive), .optTx(optTx),
    .optTxEnable(optTxEnable), .optRxEnable(optRxEnable), .optRx(optRx),
    .counter0Clock(counter0Clock), .counter1Clock(counter1Clock),
    .highPriorityInt(highPriorityInt), .lowPriorityInt(lowPriorityInt));
  ssg_pin_model ssg_pin_model_inst (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
    .pad(pad));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==========================================
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic sfrWr(input logic [7:0] a, input ssg_byte_t d);
    sfrReq = '{1'b1, a, d};
    tick(1);
    sfrReq.wr = 1'b0;
  endtask : sfrWr
  task automatic sfrRd(input logic [7:0] a, output ssg_byte_t d);
    sfrReq.addr = a;
    tick(1);
    d = sfrRdData;
  endtask : sfrRd
  task automatic ramWr(input logic [15:0] a, input ssg_byte_t d);
    ramReq = '{1'b1, a, d};
    tick(1);
    ramReq.wr = 1'b0;
  endtask : ramWr
  task automatic ramRd(input logic [15:0] a, output ssg_byte_t d);
    ramReq.addr = a;
    tick(1);
    d = ramRdData;
  endtask : ramRd
  task automatic chk(input string name, input ssg_byte_t exp, input ssg_byte_t got);
    totalChecks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk
  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finalReport

  initial
  begin
    #60000;
    mismatches++;
    finalReport();
  end

  // ==========================================
  // test sequence
  initial
  begin
    rst = 1'b1;
    sfrReq = '0;
    ramReq = '0;
    segDrive = '0;
    extLevel = '0;
    optTx = 1'b0;
    optTxEnable = 1'b0;
    optRxEnable = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    tick(1);
    chk("oe_after_reset", 8'h00, 8'(|pinOe));
    extLevel[3] = 1'b1;
    sfrWr(8'h80, 8'h20);
    tick(2);
    chk("oe_before_dir", 8'h00, pinOe[7:0]);
    sfrRd(8'h80, rd);
    chk("low_inputs", 8'h08, rd);
    sfrWr(8'hA2, 8'hFF);
    tick(2);
    sfrRd(8'hA2, rd);
    chk("dir_low", 8'hFE, rd);
    chk("oe_low", 8'hFE, pinOe[7:0]);
    chk("out_low", 8'h20, pinOut[7:0]);
    sfrRd(8'h80, rd);
    chk("low_outputs", 8'h20, rd);
    sfrWr(8'hA2, 8'h00);
    segDrive[5] = 1'b1;
    ramWr(16'h2043, 8'h02);
    tick(2);
    chk("seg_pin5", 8'h03, {6'h0, pinOe[5], pinOut[5]});
    ramWr(16'h2043, 8'h00);
    tick(2);
    chk("io_pin5", 8'h00, 8'(pinOe[5]));
    ramWr(16'h212C, 8'h08);
    sfrWr(8'hB0, 8'h81);
    tick(2);
    chk("pin24", 8'h03, {6'h0, pinOe[24], pinOut[24]});
    sfrRd(8'hB0, rd);
    chk("top_data", 8'h01, rd);
    ramWr(16'h213C, 8'h09);
    tick(2);
    chk("pin40", 8'h03, {6'h0, pinOe[40], pinOut[40]});
    ramWr(16'h2200, 8'h80);
    tick(1);
    ramWr(16'h2210, 8'h10);
    tick(2);
    chk("pin56", 8'h03, {6'h0, pinOe[56], pinOut[56]});
    ramRd(16'h2200, rd);
    chk("ded_dir", 8'h80, rd);
    optTx = 1'b1;
    optTxEnable = 1'b1;
    optRxEnable = 1'b1;
    extLevel[1] = 1'b1;
    tick(3);
    chk("opt_link", 8'h07, {5'h0, pinOe[2], pinOut[2], optRx});
    optTxEnable = 1'b0;
    optRxEnable = 1'b0;
    ramWr(16'h200B, 8'h22);
    extLevel[5:4] = 2'b10;
    tick(3);
    chk("count0_or", 8'h01, 8'(counter0Clock));
    extLevel[5:4] = 2'b00;
    tick(3);
    chk("count0_low", 8'h00, 8'(counter0Clock));
    ramWr(16'h200B, 8'h33);
    extLevel[4] = 1'b1;
    tick(3);
    chk("count1", 8'h01, 8'(counter1Clock));
    for (int c = 4; c < 8; c++)
    begin
      extLevel[4] = c[1];
      ramWr(16'h200B, {5'h0, c[2:0]});
      tick(3);
      extLevel[4] = ~c[1];
      pulses = 0;
      repeat (6)
      begin
        tick(1);
        pulses += int'((c[0] ? lowPriorityInt : highPriorityInt) === 1'b1);
      end
      chk("edge_pulses", 8'h01, pulses[7:0]);
    end
    finalReport();
  end
endmodule : ssg_gpio_port_tb_top

// ===== sim/ssg_pin_model.sv
// external pad model of the shared segment port
`timescale 1ns/1ps
module ssg_pin_model
#(
  parameter int NPIN = 59
)(
  input wire logic [NPIN-1:0] pinOut,
  input wire logic [NPIN-1:0] pinOe,
  input wire logic [NPIN-1:0] extLevel,
  output logic [NPIN-1:0] pad
);
  // ==========================================
  // pad level: own drive wins, else board level
  assign pad = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : ssg_pin_model
